// ===== acrl_pkg.sv
// acrl_pkg: constants for the conversion flow control block
// assumes: single 10 MHz bus clock domain, no import by users
package acrl_pkg;
  // ======================================================
  // register map
  localparam logic [7:0] FLOW_CTL_OFFSET = 8'h05;
  // field positions in the flow control byte
  localparam int ABORT_BIT = 7;
  localparam int TRIGGER_BIT = 6;
  localparam int RESTART_BIT = 5;
  localparam int LOAD_OK_BIT = 4;
  localparam logic [7:0] FLOW_CTL_RESET = 8'h00;
  // ======================================================
  // access configuration encodings
  localparam logic [1:0] ACC_NONE = 2'h0;
  localparam logic [1:0] ACC_BUS = 2'h1;
  localparam logic [1:0] ACC_IFACE = 2'h2;
  localparam logic [1:0] ACC_BOTH = 2'h3;
endpackage

// ===== acrl_req_if.sv
// acrl_req_if: set requests from the source selector to the flag logic
// assumes: both ends on clk_i
`timescale 1ns/1ps
interface acrl_req_if;
  logic set_restart;
  logic set_trigger;
  logic set_abort;
  logic set_load_ok;
  modport src (output set_restart, set_trigger, set_abort, set_load_ok);
  modport dst (input set_restart, set_trigger, set_abort, set_load_ok);
endinterface

// ===== acrl_req_sel.sv
// acrl_req_sel: turns bus writes or interface signal edges into set requests
// assumes: interface signals are on clk_i, so no synchroniser
`timescale 1ns/1ps
module acrl_req_sel (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control
  input wire logic [1:0] access_config_i,
  // register write port
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // internal interface signals
  input wire logic if_restart_i,
  input wire logic if_trigger_i,
  input wire logic if_abort_i,
  input wire logic if_load_ok_i,
  // set requests
  acrl_req_if.src req
);
  typedef struct packed {
    logic restart;
    logic trigger;
    logic abort;
  } acrl_sel_st_t;

  acrl_sel_st_t st, next_st;
  logic bus_en;
  logic if_en;
  logic [7:0] wd;

  // ======================================================
  // source selection and edge detection
  always_comb begin
    bus_en = access_config_i == acrl_pkg::ACC_BUS;
    if_en = access_config_i == acrl_pkg::ACC_IFACE;
    wd = (bus_en && wr_i) ? wdata_i : 8'h00; // writing zero has no effect
    next_st.restart = if_restart_i;
    next_st.trigger = if_trigger_i;
    next_st.abort = if_abort_i;
    req.set_restart = wd[acrl_pkg::RESTART_BIT] | (if_en & if_restart_i & ~st.restart);
    req.set_trigger = wd[acrl_pkg::TRIGGER_BIT] | (if_en & if_trigger_i & ~st.trigger);
    req.set_abort = wd[acrl_pkg::ABORT_BIT] | (if_en & if_abort_i & ~st.abort);
    // load ok only together with restart on the bus
    req.set_load_ok = (wd[acrl_pkg::LOAD_OK_BIT] & wd[acrl_pkg::RESTART_BIT])
      | (if_en & if_restart_i & ~st.restart & if_load_ok_i);
  end

  // edge detector registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  interface_load_ok_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (if_en && $rose(if_restart_i) && if_load_ok_i) |-> req.set_load_ok)
    else $error("load ok not sampled on restart edge");
endmodule

// ===== acrl_flow_ctl.sv
// acrl_flow_ctl: restart, trigger, abort and load ok flags of the converter
// assumes: command loader, sampler and list logic share clk_i and drive status inputs
//
// Functional notes
// - idle with restart pending: fetch the first command from the list top
// - restart clears once the first command reaches the command register
// - restart sets only while enabled, held clear when disabled
// - bus zero write ignored; one while set keeps it and flags overrun
// - access_config selects bus writes or interface signals
// - interface restart while restart still set is an overrun
// - trigger mode: restart also sets trigger after end-of-list or abort
// - load ok swaps lists at next restart and clears with that swap
// - load ok forced zero when list buffering or module is off
// - bus writes of one or zero never clear a set load ok
// - interface load ok sampled at restart signal edge
// - restart mode: restart without load ok raises load ok error, unless abort
// - no load ok error on first restart after enable, stop exit, soft reset
// - restart mode: restart with trigger raises trigger error
// - abort stops conversion, sequence, list; suppresses load ok errors
// - trigger starts a sequence when idle, clears at first sampling
`timescale 1ns/1ps
module acrl_flow_ctl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // configuration
  input wire logic module_enable_i,
  input wire logic list_buffer_mode_i,
  input wire logic trigger_mode_i,
  input wire logic [1:0] access_config_i,
  input wire logic soft_reset_i,
  input wire logic stop_exit_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // internal interface
  input wire logic if_restart_i,
  input wire logic if_trigger_i,
  input wire logic if_abort_i,
  input wire logic if_load_ok_i,
  // converter status
  input wire logic conv_busy_i,
  input wire logic cmd_loaded_i,
  input wire logic sample_start_i,
  input wire logic eol_done_i,
  input wire logic abort_done_i,
  // converter control
  output logic fetch_top_o,
  output logic swap_list_o,
  output logic abort_o,
  output logic start_seq_o,
  // error events
  output logic restart_error_o,
  output logic trigger_error_o,
  output logic load_ok_error_o
);
  typedef struct packed {
    logic restart_request;
    logic trigger_request;
    logic abort_request;
    logic load_ok;
    logic fetched;
    logic first_restart;
    logic enable_q;
    logic [7:0] rdata;
    logic fetch_top;
    logic swap_list;
    logic start_seq;
    logic restart_error;
    logic trigger_error;
    logic load_ok_error;
  } acrl_st_t;

  acrl_st_t st, next_st;
  acrl_req_if req ();
  logic wr_hit;
  logic new_restart;
  logic fetch_now;
  logic aborting;

  // ======================================================
  // request source selection
  acrl_req_sel u_sel (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .access_config_i(access_config_i),
    .wr_i(wr_hit),
    .wdata_i(wdata_i),
    .if_restart_i(if_restart_i),
    .if_trigger_i(if_trigger_i),
    .if_abort_i(if_abort_i),
    .if_load_ok_i(if_load_ok_i),
    .req(req.src)
  );

  assign wr_hit = wr_i && (addr_i == acrl_pkg::FLOW_CTL_OFFSET);

  // ======================================================
  // flag next state
  always_comb begin
    next_st = st;
    new_restart = req.set_restart & ~st.restart_request;
    aborting = st.abort_request | req.set_abort;
    fetch_now = st.restart_request & ~st.fetched & ~conv_busy_i;
    next_st.enable_q = module_enable_i;
    next_st.fetch_top = fetch_now;
    next_st.swap_list = fetch_now & st.load_ok;
    next_st.fetched = (st.fetched | fetch_now) & ~cmd_loaded_i;
    // set wins over the status clear on the restart, trigger and abort flags
    next_st.restart_request = (st.restart_request & ~cmd_loaded_i) | req.set_restart;
    next_st.trigger_request = (st.trigger_request & ~sample_start_i) | req.set_trigger
      | (trigger_mode_i & new_restart & (eol_done_i | aborting));
    next_st.abort_request = (st.abort_request & ~abort_done_i) | req.set_abort;
    // load ok sets only with restart, never cleared by writes, cleared by swap
    // an overrun restart carries no load ok, else it would outlive its restart
    next_st.load_ok = ((st.load_ok & ~(fetch_now & st.load_ok))
      | (req.set_load_ok & ~st.restart_request)) & list_buffer_mode_i;
    next_st.start_seq = st.trigger_request & ~st.restart_request & ~conv_busy_i;
    // overruns on restart and trigger
    next_st.restart_error = req.set_restart & st.restart_request;
    next_st.trigger_error = (req.set_trigger & st.trigger_request)
      | (~trigger_mode_i & next_st.restart_request & next_st.trigger_request
      & ~(st.restart_request & st.trigger_request));
    next_st.load_ok_error = ~trigger_mode_i & new_restart & ~next_st.load_ok
      & ~aborting & ~st.first_restart;
    next_st.first_restart = st.first_restart & ~new_restart;
    if (stop_exit_i || (module_enable_i && !st.enable_q)) begin
      next_st.first_restart = 1'b1;
    end
    if (!module_enable_i || soft_reset_i) begin
      next_st.restart_request = 1'b0;
      next_st.trigger_request = 1'b0;
      next_st.abort_request = 1'b0;
      next_st.load_ok = 1'b0;
      next_st.fetched = 1'b0;
      next_st.first_restart = 1'b1;
      next_st.fetch_top = 1'b0;
      next_st.swap_list = 1'b0;
      next_st.start_seq = 1'b0;
      next_st.restart_error = 1'b0;
      next_st.trigger_error = 1'b0;
      next_st.load_ok_error = 1'b0;
    end
    next_st.rdata = acrl_pkg::FLOW_CTL_RESET;
    next_st.rdata[acrl_pkg::ABORT_BIT] = next_st.abort_request;
    next_st.rdata[acrl_pkg::TRIGGER_BIT] = next_st.trigger_request;
    next_st.rdata[acrl_pkg::RESTART_BIT] = next_st.restart_request;
    next_st.rdata[acrl_pkg::LOAD_OK_BIT] = next_st.load_ok;
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign rdata_o = st.rdata;
  assign fetch_top_o = st.fetch_top;
  assign swap_list_o = st.swap_list;
  assign abort_o = st.abort_request;
  assign start_seq_o = st.start_seq;
  assign restart_error_o = st.restart_error;
  assign trigger_error_o = st.trigger_error;
  assign load_ok_error_o = st.load_ok_error;

  // ======================================================
  // checks
  sequence restart_taken_s;
    st.restart_request && !st.fetched && !conv_busy_i && module_enable_i && !soft_reset_i;
  endsequence
  sequence fetch_pulse_s;
    ##1 fetch_top_o;
  endsequence

  fetch_on_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    restart_taken_s |-> fetch_pulse_s) else $error("no fetch for pending restart");
  restart_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (st.restart_request && cmd_loaded_i && !req.set_restart) |=> !st.restart_request)
    else $error("restart not cleared on command load");
  disabled_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !module_enable_i |=> (st.rdata == acrl_pkg::FLOW_CTL_RESET))
    else $error("flags not clear while disabled");
  restart_overrun_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (module_enable_i && !soft_reset_i && st.restart_request && req.set_restart)
    |=> (restart_error_o && st.restart_request)) else $error("restart overrun missed");
  trigger_request_mode_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (module_enable_i && !soft_reset_i && trigger_mode_i && new_restart && eol_done_i)
    |=> st.trigger_request) else $error("trigger not set with restart");
  load_ok_forced_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !list_buffer_mode_i |=> !st.load_ok) else $error("load ok set without buffering");
  load_ok_swap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (fetch_now && st.load_ok && module_enable_i && !soft_reset_i && !req.set_load_ok)
    |=> (swap_list_o && !st.load_ok)) else $error("swap without load ok clear");
  load_ok_err_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    load_ok_error_o |-> (!$past(trigger_mode_i) && !abort_o && !st.load_ok))
    else $error("load ok error with abort or load ok");
  trigger_request_err_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($past(trigger_mode_i) && !$past(req.set_trigger)) |-> !trigger_error_o)
    else $error("trigger error in trigger mode");
  legal_combo_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(st.load_ok && !st.restart_request && !st.fetched && !st.swap_list))
    else $error("load ok without restart");
endmodule

// ===== acrl_conv_model.sv
// acrl_conv_model: converter stand-in answering fetch, trigger and abort
// assumes: fed by acrl_flow_ctl outputs, answers on falling edges of clk_i
`timescale 1ns/1ps
module acrl_conv_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // answer delay in falling edges
  input wire logic [1:0] delay_i,
  // requests from the flag logic
  input wire logic fetch_top_i,
  input wire logic abort_i,
  input wire logic start_seq_i,
  // status back to the flag logic
  output logic conv_busy_o,
  output logic cmd_loaded_o = 1'h0,
  output logic sample_start_o = 1'h0,
  output logic abort_done_o = 1'h0
);
  // ======================================================
  // job engine
  logic [1:0] job = 2'h0;
  logic [1:0] cnt = 2'h0;
  logic pend = 1'h0;
  assign conv_busy_o = (job != 2'h0);
  // one job at a time; a fetch seen while busy is kept pending, not lost
  always @(negedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      job <= 2'h0;
      cnt <= 2'h0;
      pend <= 1'h0;
      cmd_loaded_o <= 1'h0;
      sample_start_o <= 1'h0;
      abort_done_o <= 1'h0;
    end else begin
      cmd_loaded_o <= 1'h0;
      sample_start_o <= 1'h0;
      abort_done_o <= 1'h0;
      if (fetch_top_i) begin
        pend <= 1'h1;
      end
      if (job == 2'h0) begin
        cnt <= delay_i;
        if (abort_i) begin
          job <= 2'h3;
        end else if (pend || fetch_top_i) begin
          job <= 2'h1;
          pend <= 1'h0;
        end else if (start_seq_i) begin
          job <= 2'h2;
        end
      end else if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else begin
        cmd_loaded_o <= (job == 2'h1);
        sample_start_o <= (job == 2'h2);
        abort_done_o <= (job == 2'h3);
        job <= 2'h0;
      end
    end
  end
endmodule

// ===== adc_restart_and_list_swap_control_test.sv
// adc_restart_and_list_swap_control_test: self-checking bench of the flow control flags
// assumes: acrl_flow_ctl as top, acrl_conv_model as converter stand-in
`timescale 1ns/1ps
module adc_restart_and_list_swap_control_test;
  // ======================================================
  // signals and instances
  logic clk_i = 1'h0, rstn_i = 1'h0, module_enable_i = 1'h0, list_buffer_mode_i = 1'h0;
  logic trigger_mode_i = 1'h0, soft_reset_i = 1'h0, stop_exit_i = 1'h0, wr_i = 1'h0;
  logic if_restart_i = 1'h0, if_trigger_i = 1'h0, if_abort_i = 1'h0, if_load_ok_i = 1'h0;
  logic eol_done_i = 1'h1;
  logic [1:0] access_config_i = 2'h0, dly = 2'h3;
  logic [7:0] addr_i = 8'h05, wdata_i = 8'h00, rdata_o;
  logic conv_busy_i, cmd_loaded_i, sample_start_i, abort_done_i, fetch_top_o, swap_list_o;
  logic abort_o, start_seq_o, restart_error_o, trigger_error_o, load_ok_error_o;
  int fails = 0, compares = 0, seed = 60684;
  int n[3] = '{0, 0, 0}, s[3] = '{0, 0, 0};
  acrl_flow_ctl u_acrl_flow_ctl (.clk_i, .rstn_i, .module_enable_i, .list_buffer_mode_i,
    .trigger_mode_i, .access_config_i, .soft_reset_i, .stop_exit_i, .addr_i, .wr_i, .wdata_i,
    .rdata_o, .if_restart_i, .if_trigger_i, .if_abort_i, .if_load_ok_i, .conv_busy_i,
    .cmd_loaded_i, .sample_start_i, .eol_done_i, .abort_done_i, .fetch_top_o, .swap_list_o,
    .abort_o, .start_seq_o, .restart_error_o, .trigger_error_o, .load_ok_error_o);
  acrl_conv_model u_acrl_conv_model (.clk_i, .rstn_i, .delay_i(dly), .fetch_top_i(fetch_top_o),
    .abort_i(abort_o), .start_seq_i(start_seq_o), .conv_busy_o(conv_busy_i),
    .cmd_loaded_o(cmd_loaded_i), .sample_start_o(sample_start_i), .abort_done_o(abort_done_i));
  // clock, error pulse counting, watchdog
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n[0] <= n[0] + int'(restart_error_o === 1'h1);
    n[1] <= n[1] + int'(trigger_error_o === 1'h1);
    n[2] <= n[2] + int'(load_ok_error_o === 1'h1);
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    fails++;
    tally_and_finish;
  end
  // ======================================================
  // tasks
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic errs(input int r, input int t, input int l);
    repeat (14) @(negedge clk_i);
    compares++;
    if (n[0] - s[0] != r || n[1] - s[1] != t || n[2] - s[2] != l) begin
      fails++;
      $display("mismatch error pulses expected %0d %0d %0d seen %0d %0d %0d", r, t, l,
        n[0] - s[0], n[1] - s[1], n[2] - s[2]);
    end
    s = n;
  endtask
  task automatic wr_b(input logic [7:0] d);
    @(negedge clk_i);
    wdata_i = d;
    wr_i = 1'h1;
    @(negedge clk_i);
    wr_i = 1'h0;
    @(negedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ======================================================
  // scenarios
  initial begin
    repeat (12) @(negedge clk_i);
    rstn_i = 1'h1;
    cmp("flow byte", 8'h00, rdata_o);
    module_enable_i = 1'h1;
    list_buffer_mode_i = 1'h1;
    access_config_i = 2'h1;
    wr_b(8'h30);
    // fetch already taken: swap cleared load ok, restart still pending
    cmp("flow byte", 8'h20, rdata_o);
    for (int i = 0; i < 20 && fetch_top_o !== 1'h1; i++)
      @(negedge clk_i);
    cmp("swap", 8'h01, {7'h00, swap_list_o});
    errs(0, 0, 0);
    cmp("flow byte", 8'h00, rdata_o);
    wr_b(8'h10);
    cmp("flow byte", 8'h00, rdata_o);
    // restart written three times back to back, last with zero
    wdata_i = 8'h20;
    wr_i = 1'h1;
    repeat (2) @(negedge clk_i);
    wdata_i = 8'h00;
    @(negedge clk_i);
    wr_i = 1'h0;
    cmp("restart bit", 8'h20, rdata_o & 8'h20);
    errs(1, 0, 1);
    wr_b(8'h60);
    errs(0, 1, 1);
    trigger_mode_i = 1'h1;
    wr_b(8'h20);
    cmp("flow byte", 8'h60, rdata_o);
    cmp("start seq", 8'h00, {7'h00, start_seq_o});
    for (int i = 0; i < 20 && start_seq_o !== 1'h1; i++)
      @(negedge clk_i);
    cmp("start seq", 8'h01, {7'h00, start_seq_o});
    errs(0, 0, 0);
    trigger_mode_i = 1'h0;
    wr_b(8'hA0);
    cmp("abort", 8'h01, {7'h00, abort_o});
    errs(0, 0, 0);
    soft_reset_i = 1'h1;
    @(negedge clk_i);
    soft_reset_i = 1'h0;
    wr_b(8'h20);
    errs(0, 0, 0);
    stop_exit_i = 1'h1;
    @(negedge clk_i);
    stop_exit_i = 1'h0;
    wr_b(8'h20);
    errs(0, 0, 0);
    list_buffer_mode_i = 1'h0;
    wr_b(8'h30);
    cmp("flow byte", 8'h20, rdata_o);
    errs(0, 0, 1);
    list_buffer_mode_i = 1'h1;
    module_enable_i = 1'h0;
    wr_b(8'h30);
    cmp("flow byte", 8'h00, rdata_o);
    module_enable_i = 1'h1;
    addr_i = 8'h06;
    wr_b(8'h20);
    cmp("flow byte", 8'h00, rdata_o);
    addr_i = 8'h05;
    for (int i = 0; i < 3; i++) begin
      access_config_i = 2'(i + (i + 1) / 2);
      wr_b(8'h20);
      cmp("flow byte", 8'h00, rdata_o);
    end
    access_config_i = 2'h2;
    if_load_ok_i = 1'h1;
    if_restart_i = 1'h1;
    for (int i = 0; i < 8 && rdata_o[5] !== 1'h1; i++)
      @(negedge clk_i);
    cmp("flow byte", 8'h30, rdata_o);
    if_restart_i = 1'h0;
    if_load_ok_i = 1'h0;
    @(negedge clk_i);
    if_restart_i = 1'h1;
    @(negedge clk_i);
    if_restart_i = 1'h0;
    errs(1, 0, 0);
    // random traffic on bus, interface, access config, trigger mode, eol and delay inputs
    repeat (300) begin
      @(negedge clk_i);
      addr_i = $random(seed) & 1 ? 8'h05 : 8'h06;
      wr_i = 1'($random(seed));
      wdata_i = 8'($random(seed));
      {if_restart_i, if_trigger_i, if_abort_i, if_load_ok_i} = 4'($random(seed));
      {access_config_i, trigger_mode_i, eol_done_i} = 4'($random(seed));
      dly = 2'($random(seed));
      cmp("load ok alone", 8'h00, {7'h00, rdata_o[4] & ~rdata_o[5]});
    end
    tally_and_finish;
  end
endmodule
